// ---- pls_defines.svh ----
// Constants for the PCM port line selection and test loop block
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH
`define PLS_MODE_0       2'h0
`define PLS_MODE_1       2'h1
`define PLS_MODE_2       2'h2
`define PLS_NUM_LINES    4
`define PLS_CLK_PERIOD_NS 4
`define PLS_CNT_W        4
`define PLS_CNT_MAX      4'hf
`endif

// ---- pls_pkg.sv ----
// Types for the PCM port line selection and test loop block
package pls_pkg;
  typedef logic [1:0] pls_mode_t;
  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] fs_sync;
    logic [3:0] rx_sync0;
    logic [3:0] rx_sync1;
    logic       clk_prev;
    logic       fs_smp;
    logic       fs_smp_prev;
    logic       frame_start;
    logic [1:0] port_rx;
    logic [3:0] tx_data;
    logic [3:0] tx_oe;
    logic [3:0] tsc_out;
    logic [1:0] mismatch;
    logic [3:0] line_rx;
  } pls_state_s;
endpackage

// ---- pls_line_select.sv ----
// PCM highway port line selection, comparison, standby and test loop
`timescale 1ns/10ps
`include "pls_defines.svh"

// Operation
// - Each logical port transmits on its fixed physical line; mode 1 port 1 uses line 2.
// - Mode 1: port 0 takes line 0 or 1, port 1 line 2 or 3.
// - Mode 2: single port takes line 2 or 3; select bit 0 ignored.
// - Modes 1 and 2 mirror select bits 0 and 1 on control pins 1 and 3.
// - Enabled comparison flags mismatches between two receive lines.
// - Comparison works in every PCM mode.
// - Compare bit 0 checks lines 0 and 1; bit 1 checks lines 2 and 3.
// - Standby bit 0 floats all transmit lines and forces used controls to 1.
// - Standby keeps receive path and comparison operating.
// - Standby bit 1 transmits upstream data unless the tristate field floats it.
// - Test loop routes each transmit line to its receive input, ignoring pins.
// - Test loop still drives transmit pins as in normal operation.
// - Frame sync sampled on clock falling edge if sync mode 0, rising if 1.
module pls_line_select
  import pls_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] pcm_mode_register,
  input  wire logic       alt_select_bit0,
  input  wire logic       alt_select_bit1,
  input  wire logic       compare_enable_bit0,
  input  wire logic       compare_enable_bit1,
  input  wire logic       standby_bit,
  input  wire logic       test_loop_bit,
  input  wire logic       sync_mode_bit,
  input  wire logic       pcm_clock,
  input  wire logic       frame_sync,
  input  wire logic [3:0] rx_line,
  input  wire logic [3:0] port_tx_data,
  input  wire logic [3:0] port_tx_tristate,
  input  wire logic [3:0] port_tsc,
  output logic      [3:0] tx_line_out,
  output logic      [3:0] tx_line_oe,
  output logic      [3:0] tristate_control_pin,
  output logic      [1:0] port_rx_data,
  output logic      [3:0] rx_line_data,
  output logic      [1:0] compare_mismatch,
  output logic            frame_start
);

  pls_state_s st_r;
  pls_state_s st_nxt;

  // Logical port to physical transmit line, per mode
  function automatic logic [3:0] tx_route(input logic [1:0] mode, input logic [3:0] d);
    case (mode)
      `PLS_MODE_0: tx_route = d;
      `PLS_MODE_1: tx_route = {1'b0, d[1], 1'b0, d[0]};
      `PLS_MODE_2: tx_route = {3'h0, d[0]};
      default:     tx_route = 4'h0;
    endcase
  endfunction

  // Physical lines actually driven in each mode
  function automatic logic [3:0] used_lines(input logic [1:0] mode);
    case (mode)
      `PLS_MODE_0: used_lines = 4'hf;
      `PLS_MODE_1: used_lines = 4'h5;
      `PLS_MODE_2: used_lines = 4'h1;
      default:     used_lines = 4'h0;
    endcase
  endfunction

  logic       multi_mode;
  logic [3:0] tx_data_c;
  logic [3:0] tx_oe_c;
  logic [3:0] loop_src;
  logic       clk_rise;
  logic       clk_fall;

  always_comb begin
    st_nxt     = st_r;
    multi_mode = (pcm_mode_register == `PLS_MODE_1) || (pcm_mode_register == `PLS_MODE_2);
    clk_rise   = st_r.clk_sync[1] & ~st_r.clk_prev;
    clk_fall   = ~st_r.clk_sync[1] & st_r.clk_prev;
    tx_data_c  = tx_route(pcm_mode_register, port_tx_data);
    tx_oe_c    = tx_route(pcm_mode_register, ~port_tx_tristate)
               & used_lines(pcm_mode_register);
    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    st_nxt.clk_sync = {st_r.clk_sync[0], pcm_clock};
    st_nxt.fs_sync  = {st_r.fs_sync[0], frame_sync};
    st_nxt.rx_sync0 = rx_line;
    st_nxt.rx_sync1 = st_r.rx_sync0;
    st_nxt.clk_prev = st_r.clk_sync[1];
    // -----------------------------------------------------------------
    // Frame sync sampling
    // -----------------------------------------------------------------
    st_nxt.frame_start = 1'b0;
    if ((sync_mode_bit && clk_rise) || (!sync_mode_bit && clk_fall)) begin
      st_nxt.fs_smp      = st_r.fs_sync[1];
      st_nxt.fs_smp_prev = st_r.fs_smp;
      st_nxt.frame_start = st_r.fs_sync[1] & ~st_r.fs_smp;
    end
    // -----------------------------------------------------------------
    // Transmit side
    // -----------------------------------------------------------------
    st_nxt.tx_data = tx_data_c;
    st_nxt.tx_oe   = standby_bit ? tx_oe_c : 4'h0;
    case (pcm_mode_register)
      `PLS_MODE_1: st_nxt.tsc_out = {alt_select_bit1, port_tsc[1],
                                     alt_select_bit0, port_tsc[0]};
      `PLS_MODE_2: st_nxt.tsc_out = {alt_select_bit1, 1'b1,
                                     alt_select_bit0, port_tsc[0]};
      default:     st_nxt.tsc_out = port_tsc;
    endcase
    // Only genuine tristate controls go inactive; mirrored select bits keep
    // steering the external relays so the redundant line stays chosen.
    if (!standby_bit) begin
      st_nxt.tsc_out[0] = 1'b1;
      if (!multi_mode) begin
        st_nxt.tsc_out = 4'hf;
      end else if (pcm_mode_register == `PLS_MODE_1) begin
        st_nxt.tsc_out[2] = 1'b1;
      end
    end
    // -----------------------------------------------------------------
    // Receive side and test loop
    // -----------------------------------------------------------------
    // Loop takes the pin value as driven; floated lines loop back as 1
    loop_src = (st_r.tx_data & st_r.tx_oe) | ~st_r.tx_oe;
    st_nxt.line_rx = test_loop_bit ? loop_src : st_r.rx_sync1;
    case (pcm_mode_register)
      `PLS_MODE_1: st_nxt.port_rx = {alt_select_bit1 ? st_r.line_rx[2] : st_r.line_rx[3],
                                     alt_select_bit0 ? st_r.line_rx[0] : st_r.line_rx[1]};
      `PLS_MODE_2: st_nxt.port_rx = {1'b0,
                                     alt_select_bit1 ? st_r.line_rx[2] : st_r.line_rx[3]};
      default:     st_nxt.port_rx = st_r.line_rx[1:0];
    endcase
    // Comparison runs regardless of mode or standby
    st_nxt.mismatch[0] = compare_enable_bit0 & (st_r.line_rx[0] ^ st_r.line_rx[1]);
    st_nxt.mismatch[1] = compare_enable_bit1 & (st_r.line_rx[2] ^ st_r.line_rx[3]);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.tsc_out <= 4'hf;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign tx_line_out          = st_r.tx_data;
  assign tx_line_oe           = st_r.tx_oe;
  assign tristate_control_pin = st_r.tsc_out;
  assign port_rx_data         = st_r.port_rx;
  assign rx_line_data         = st_r.line_rx;
  assign compare_mismatch     = st_r.mismatch;
  assign frame_start          = st_r.frame_start;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  a_standby_floats: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !standby_bit) |=> (tx_line_oe == 4'h0))
    else $error("transmit driven in standby");
  a_unused_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && multi_mode) |=> (tx_line_oe[1] == 1'b0 && tx_line_oe[3] == 1'b0))
    else $error("unused transmit line driven");
  a_mode1_tx_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_1) |=> (tx_line_out[2] == $past(port_tx_data[1])))
    else $error("port 1 not on line 2");
  a_tsc_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && multi_mode) |=> (tristate_control_pin[3] == $past(alt_select_bit1)
                                && tristate_control_pin[1] == $past(alt_select_bit0)))
    else $error("select bits not mirrored");
  a_mode1_rx_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_1 && alt_select_bit0)
      |=> (port_rx_data[0] == $past(rx_line_data[0])))
    else $error("port 0 wrong receive line");
  a_mode2_rx_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_2 && !alt_select_bit1)
      |=> (port_rx_data[0] == $past(rx_line_data[3])))
    else $error("mode 2 wrong receive line");
  a_compare_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && compare_enable_bit1 && (rx_line_data[2] != rx_line_data[3]))
      |=> compare_mismatch[1])
    else $error("mismatch not flagged");
  a_compare_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !compare_enable_bit0) |=> !compare_mismatch[0])
    else $error("disabled compare flagged");
  a_loop_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && test_loop_bit && tx_line_oe[0])
      |=> (rx_line_data[0] == $past(tx_line_out[0])))
    else $error("loop not routed");
  a_mode1_rx_alt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_1 && !alt_select_bit0)
      |=> (port_rx_data[0] == $past(rx_line_data[1])))
    else $error("port 0 wrong redundant line");
  a_mode1_port1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_1 && alt_select_bit1)
      |=> (port_rx_data[1] == $past(rx_line_data[2])))
    else $error("port 1 wrong receive line");
  a_mode2_rx_alt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && pcm_mode_register == `PLS_MODE_2 && alt_select_bit1)
      |=> (port_rx_data[0] == $past(rx_line_data[2])))
    else $error("mode 2 wrong primary line");
  a_standby_tsc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !standby_bit && pcm_mode_register == `PLS_MODE_0)
      |=> (tristate_control_pin == 4'hf))
    else $error("control pin active in standby");
  a_tx_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && standby_bit && pcm_mode_register == `PLS_MODE_0 && !port_tx_tristate[0])
      |=> (tx_line_oe[0] && tx_line_out[0] == $past(port_tx_data[0])))
    else $error("line 0 not transmitting");
  a_loop_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && test_loop_bit && !tx_line_oe[0]) |=> rx_line_data[0])
    else $error("floated line not looped as 1");
  a_frame_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && frame_start) |=> !frame_start)
    else $error("frame start longer than one cycle");

endmodule // pls_line_select

// ---- pls_pcm_model.sv ----
// Behavioural PCM highway: free running data clock, frame pulse and receive lines
`timescale 1ns/10ps
module pls_pcm_model (
  input  wire logic [3:0] rx_pat,
  output logic            pcm_clock,
  output logic            frame_sync,
  output logic      [3:0] rx_line
);
  logic [2:0] bit_cnt;

  initial begin
    pcm_clock  = 1'b0;
    frame_sync = 1'b0;
    bit_cnt    = 3'h0;
  end

  // ----------------------------------------------------------------
  // Highway clock and framing
  // ----------------------------------------------------------------
  // Frame pulse rises just after the clock rise, so the two edges all but coincide
  always begin
    #62.5;
    pcm_clock = ~pcm_clock;
  end

  always @(posedge pcm_clock) begin
    bit_cnt    <= bit_cnt + 3'h1;
    frame_sync <= #1 (bit_cnt == 3'h0);
  end

  assign rx_line = rx_pat;
endmodule // pls_pcm_model

// ---- testbench.sv ----
// Self-checking bench for the PCM port line selection block
`timescale 1ns/10ps
module testbench;
  import pls_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, sb = 1'b1, tl = 1'b0, sm = 1'b0;
  logic ce = 1'b1;
  logic [1:0] mode = 2'h0, alt = 2'h0, cen = 2'h0;
  logic [3:0] dat = 4'h0, tri_f = 4'h0, tsc = 4'hf, rx_pat = 4'h0;
  logic [3:0] tx_out, tx_oe, tsc_pin, rx_data;
  logic [1:0] p_rx, mis;
  logic       fs_pulse, pclk, fsync;
  logic [3:0] rx_line;
  int         bad_count = 0, num_checks = 0;

  always #2 ref_clk = ~ref_clk;

  pls_pcm_model u_pcm (.rx_pat(rx_pat), .pcm_clock(pclk), .frame_sync(fsync), .rx_line(rx_line));

  pls_line_select dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .pcm_mode_register(mode),
    .alt_select_bit0(alt[0]), .alt_select_bit1(alt[1]), .compare_enable_bit0(cen[0]),
    .compare_enable_bit1(cen[1]), .standby_bit(sb), .test_loop_bit(tl), .sync_mode_bit(sm),
    .pcm_clock(pclk), .frame_sync(fsync), .rx_line(rx_line), .port_tx_data(dat),
    .port_tx_tristate(tri_f), .port_tsc(tsc), .tx_line_out(tx_out), .tx_line_oe(tx_oe),
    .tristate_control_pin(tsc_pin), .port_rx_data(p_rx), .rx_line_data(rx_data),
    .compare_mismatch(mis), .frame_start(fs_pulse));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] a, input logic [1:0] c,
                     input logic s, input logic l);
    @(posedge ref_clk);
    mode <= m;
    alt  <= a;
    cen  <= c;
    sb   <= s;
    tl   <= l;
    repeat (7) @(posedge ref_clk);
    #1;
  endtask

  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_tx;
    logic [3:0] eo;
    logic [3:0] ed;
    logic [3:0] et;
    @(posedge ref_clk);
    dat   <= 4'h5;
    tri_f <= 4'h2;
    tsc   <= 4'h6;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        cfg(m[1:0], (m == 0) ? 2'b00 : 2'b01, 2'b00, s[0], 1'b0);
        eo = 4'h0;
        ed = 4'h0;
        et = s[0] ? tsc : 4'hf;
        case (m)
          0: begin
            eo = ~tri_f;
            ed = dat;
          end
          1: begin
            eo = {1'b0, ~tri_f[1], 1'b0, ~tri_f[0]};
            ed = {1'b0, dat[1], 1'b0, dat[0]};
            et = {alt[1], s[0] ? tsc[1] : 1'b1, alt[0], s[0] ? tsc[0] : 1'b1};
          end
          2: begin
            eo = {3'h0, ~tri_f[0]};
            ed = {3'h0, dat[0]};
            et = {alt[1], 1'b1, alt[0], s[0] ? tsc[0] : 1'b1};
          end
          default: begin
            // Mode 3 drives no line; controls pass through as in mode 0
            eo = 4'h0;
          end
        endcase
        if (s == 0) eo = 4'h0;
        chk(tx_oe, eo);
        chk(tx_out & eo, ed & eo);
        chk(tsc_pin, et);
      end
    end
  endtask

  task automatic t_rx;
    @(posedge ref_clk);
    rx_pat <= 4'h6;
    cfg(2'h1, 2'b00, 2'b00, 1'b0, 1'b0);
    chk({2'h0, p_rx}, 4'h1);
    chk(rx_data, 4'h6);
    cfg(2'h1, 2'b11, 2'b00, 1'b1, 1'b0);
    chk({2'h0, p_rx}, 4'h2);
    cfg(2'h2, 2'b10, 2'b00, 1'b1, 1'b0);
    chk({2'h0, p_rx}, 4'h1);
    cfg(2'h2, 2'b01, 2'b00, 1'b1, 1'b0);
    chk({2'h0, p_rx}, 4'h0);
  endtask

  task automatic t_cmp;
    @(posedge ref_clk);
    rx_pat <= 4'h6;
    for (int c = 0; c < 4; c++) begin
      cfg(2'h0, 2'b00, c[1:0], 1'b1, 1'b0);
      chk({2'h0, mis}, {2'h0, c[1:0]});
    end
    cfg(2'h2, 2'b00, 2'b11, 1'b0, 1'b0);
    chk({2'h0, mis}, 4'h3);
    @(posedge ref_clk);
    rx_pat <= 4'h0;
    cfg(2'h2, 2'b00, 2'b11, 1'b1, 1'b0);
    chk({2'h0, mis}, 4'h0);
  endtask

  task automatic t_loop;
    @(posedge ref_clk);
    rx_pat <= 4'h5;
    dat    <= 4'ha;
    tri_f  <= 4'h0;
    cfg(2'h0, 2'b00, 2'b00, 1'b1, 1'b1);
    chk(rx_data, 4'ha);
    chk(tx_oe, 4'hf);
    @(posedge ref_clk);
    tri_f <= 4'h1;
    cfg(2'h0, 2'b00, 2'b00, 1'b1, 1'b1);
    chk(rx_data, 4'hb);
    cfg(2'h0, 2'b00, 2'b00, 1'b1, 1'b0);
    chk(rx_data, 4'h5);
  endtask

  // Clock enable freeze, then a reset in mid-run
  task automatic t_ctl;
    @(posedge ref_clk);
    ce  <= 1'b0;
    dat <= 4'h5;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(tx_out, 4'ha);
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(tx_out, 4'h5);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(tsc_pin, 4'hf);
    chk(tx_oe, 4'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(tx_oe, 4'he);
  endtask

  task automatic t_fs;
    int n;
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      sm <= s[0];
      n = 0;
      repeat (300) @(posedge ref_clk);
      repeat (1000) begin
        @(posedge ref_clk);
        #1;
        if (fs_pulse === 1'b1) n++;
      end
      chk((n > 15) ? 4'hf : n[3:0], 4'h4);
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_tx();
    t_rx();
    t_cmp();
    t_loop();
    t_ctl();
    t_fs();
    finish_test();
  end

  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule // testbench
